/* logic/kms_pkg.sv */
// ----------------------------------------------------------------------------
// Overview of operation
// - Scan up to four driven rows and five sensed columns.
// - Normal code holds row in upper nibble, column in lower nibble.
// - Long code is the normal code with bit 7 set.
// - Normal key needs qualification over samples; long key stays held the long period.
// - Up to three simultaneous keys are captured into three code registers.
// - Captured codes are stored in ascending order, lowest code first.
// - Second control register bits 1:0 show the count of keys pressed.
// - First control bits 5:4 pick sample count, bits 2:0 scan rate.
// - Second control bits 3:2 pick the long key hold duration.
// - With second control bit 7 set, a qualified keystroke wakes from sleep.
// - Enable bit 4 gates the interrupt; flag bit 4 sets on key events.
// - The flag sets on a key event whether polled or interrupt driven.
// - Host clears the flag after reading codes; no new interrupt meanwhile.
// - A wake-up keystroke may raise the interrupt output or be polled.
// - The keystroke that wakes the device is not recorded as a code.
// ----------------------------------------------------------------------------
package kms_pkg;

   // -------------------------------------------------------------------------
   // Matrix geometry and register map
   // -------------------------------------------------------------------------
   localparam int ROWS = 4;
   localparam int COLS = 5;
   localparam int KEYS = 20;
   localparam int MAX_CODES = 3;
   localparam logic [7:0] ADDR_CTL_ONE = 8'hC0;
   localparam logic [7:0] ADDR_CTL_TWO = 8'hC1;
   localparam logic [7:0] ADDR_CODE_FIRST = 8'hC2;
   localparam logic [7:0] ADDR_CODE_SECOND = 8'hC3;
   localparam logic [7:0] ADDR_CODE_THIRD = 8'hC4;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hF0;
   localparam logic [7:0] ADDR_IRQ_FLAG = 8'hF1;

   // -------------------------------------------------------------------------
   // Field positions and reset values
   // -------------------------------------------------------------------------
   localparam int CTL1_SCAN_EN = 7;
   localparam int CTL1_LONG_EN = 6;
   localparam int CTL1_SAMP_LO = 4;
   localparam int CTL1_FREQ_LO = 0;
   localparam int CTL2_WAKE_EN = 7;
   localparam int CTL2_LONG_LO = 2;
   localparam int IRQ_KEY_BIT = 4;
   localparam int LONG_CODE_BIT = 7;
   localparam logic [7:0] CTL1_WRITE_MASK = 8'hF7;
   localparam logic [7:0] CTL1_RESET = 8'h00;
   localparam logic [7:0] CODE_RESET = 8'h00;

   // -------------------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int SCAN_BASE_NS = 10000;
   localparam int SCAN_BASE_CYCLES = (SCAN_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DIV_W = 20;
   localparam int SAMPLE_BASE_FRAMES = 2;
   localparam int LONG_BASE_FRAMES = 16;

endpackage : kms_pkg

/* logic/kms_keypad_scanner.sv */
// Local design decision: strobed register access.
module kms_keypad_scanner #(
   parameter int unsigned SCAN_BASE_CYCLES = kms_pkg::SCAN_BASE_CYCLES
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   // Register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   // Key matrix
   output logic [kms_pkg::ROWS-1:0] row_drive_outputs_out,
   input wire logic [kms_pkg::COLS-1:0] column_sense_inputs_in,
   // Power management
   input wire logic sleep_in,
   output logic wake_out,
   // Interrupt
   output logic irq_out
);

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic [7:0] ctl_one;
      logic wake_en;
      logic [1:0] long_sel;
      logic [1:0] key_cnt;
      logic irq_en;
      logic irq_flag;
      logic [7:0] code_first;
      logic [7:0] code_second;
      logic [7:0] code_third;
      logic [kms_pkg::DIV_W-1:0] div_cnt;
      logic [1:0] row_idx;
      logic [kms_pkg::ROWS-1:0] rows;
      logic [kms_pkg::KEYS-1:0] row_acc;
      logic [kms_pkg::KEYS-1:0] last_snap;
      logic [kms_pkg::KEYS-1:0] qual_map;
      logic [4:0] stable_cnt;
      logic [8:0] long_cnt;
      logic long_done;
      logic suppress;
      logic wake;
      logic irq;
      logic [7:0] rdata;
   } kms_state_t;

   kms_state_t s;
   kms_state_t next_s;

   // -------------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------------
   // Walking keys in row-major order yields codes in ascending order.
   function automatic logic [23:0] kms_sort_codes(input logic [kms_pkg::KEYS-1:0] keys, input logic long_key);
      logic [23:0] codes;
      int slot;
      codes = '0;
      slot = 0;
      for (int r = 0; r < kms_pkg::ROWS; r++) begin
         for (int c = 0; c < kms_pkg::COLS; c++) begin
            if (keys[r * kms_pkg::COLS + c] && slot < kms_pkg::MAX_CODES) begin
               codes[slot * 8 +: 8] = {long_key, 1'b0, 2'(r), 1'b0, 3'(c)};
               slot = slot + 1;
            end
         end
      end
      return codes;
   endfunction : kms_sort_codes

   function automatic logic [1:0] kms_key_count(input logic [kms_pkg::KEYS-1:0] keys);
      int n;
      n = 0;
      for (int i = 0; i < kms_pkg::KEYS; i++) begin
         n = n + int'(keys[i]);
      end
      return (n > 3) ? 2'h3 : 2'(n);
   endfunction : kms_key_count

   // -------------------------------------------------------------------------
   // Derived settings
   // -------------------------------------------------------------------------
   logic scan_en;
   logic long_en;
   logic [kms_pkg::DIV_W-1:0] row_period;
   logic tick;
   logic [4:0] samples_needed;
   logic [8:0] long_target;
   logic [kms_pkg::KEYS-1:0] snap;
   logic [4:0] stable_next;
   logic [23:0] normal_codes;
   logic [23:0] long_codes;

   assign scan_en = s.ctl_one[kms_pkg::CTL1_SCAN_EN];
   assign long_en = s.ctl_one[kms_pkg::CTL1_LONG_EN];
   assign row_period = kms_pkg::DIV_W'(SCAN_BASE_CYCLES) << s.ctl_one[kms_pkg::CTL1_FREQ_LO +: 3];
   assign tick = (s.div_cnt >= row_period - kms_pkg::DIV_W'(1));
   assign samples_needed = 5'(kms_pkg::SAMPLE_BASE_FRAMES) << s.ctl_one[kms_pkg::CTL1_SAMP_LO +: 2];
   assign long_target = 9'(kms_pkg::LONG_BASE_FRAMES) << s.long_sel;

   always_comb begin
      snap = s.row_acc;
      snap[s.row_idx * kms_pkg::COLS +: kms_pkg::COLS] = column_sense_inputs_in;
   end

   assign stable_next = (snap != s.last_snap) ? 5'h01 : ((s.stable_cnt == 5'h1F) ? 5'h1F : s.stable_cnt + 5'h01);
   assign normal_codes = kms_sort_codes(snap, 1'b0);
   assign long_codes = kms_sort_codes(s.qual_map, 1'b1);

   // -------------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------------
   always_comb begin
      next_s = s;
      next_s.wake = 1'b0;
      next_s.rdata = 8'h00;

      if (reg_wr_in) begin
         case (reg_addr_in)
            kms_pkg::ADDR_CTL_ONE: begin
               next_s.ctl_one = reg_wdata_in & kms_pkg::CTL1_WRITE_MASK;
            end
            kms_pkg::ADDR_CTL_TWO: begin
               next_s.wake_en = reg_wdata_in[kms_pkg::CTL2_WAKE_EN];
               next_s.long_sel = reg_wdata_in[kms_pkg::CTL2_LONG_LO +: 2];
            end
            kms_pkg::ADDR_IRQ_ENABLE: begin
               next_s.irq_en = reg_wdata_in[kms_pkg::IRQ_KEY_BIT];
            end
            kms_pkg::ADDR_IRQ_FLAG: begin
               if (reg_wdata_in[kms_pkg::IRQ_KEY_BIT]) begin
                  next_s.irq_flag = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end

      if (reg_rd_in) begin
         case (reg_addr_in)
            kms_pkg::ADDR_CTL_ONE: begin
               next_s.rdata = s.ctl_one;
            end
            kms_pkg::ADDR_CTL_TWO: begin
               next_s.rdata = {s.wake_en, 3'h0, s.long_sel, s.key_cnt};
            end
            kms_pkg::ADDR_CODE_FIRST: begin
               next_s.rdata = s.code_first;
            end
            kms_pkg::ADDR_CODE_SECOND: begin
               next_s.rdata = s.code_second;
            end
            kms_pkg::ADDR_CODE_THIRD: begin
               next_s.rdata = s.code_third;
            end
            kms_pkg::ADDR_IRQ_ENABLE: begin
               next_s.rdata = {3'h0, s.irq_en, 4'h0};
            end
            kms_pkg::ADDR_IRQ_FLAG: begin
               // Polled flag; a read also clears it.
               next_s.rdata = {3'h0, s.irq_flag, 4'h0};
               next_s.irq_flag = 1'b0;
            end
            default: begin
               next_s.rdata = 8'h00;
            end
         endcase
      end

      // Events below come after the clears so that a set in the same cycle wins.
      if (!scan_en) begin
         next_s.div_cnt = '0;
         next_s.row_idx = 2'h0;
         next_s.row_acc = '0;
         next_s.last_snap = '0;
         next_s.stable_cnt = 5'h00;
         next_s.qual_map = '0;
         next_s.key_cnt = 2'h0;
         next_s.long_cnt = 9'h000;
         next_s.long_done = 1'b0;
         next_s.suppress = 1'b0;
      end else if (!tick) begin
         next_s.div_cnt = s.div_cnt + kms_pkg::DIV_W'(1);
      end else begin
         // Columns sampled at the end of each row period.
         next_s.div_cnt = '0;
         next_s.row_acc = snap;
         next_s.row_idx = s.row_idx + 2'h1;
         if (s.row_idx == 2'(kms_pkg::ROWS - 1)) begin
            next_s.last_snap = snap;
            next_s.stable_cnt = stable_next;
            // Qualified once stable over the sample count.
            if (stable_next >= samples_needed && snap != s.qual_map) begin
               next_s.qual_map = snap;
               next_s.key_cnt = kms_key_count(snap);
               next_s.long_cnt = 9'h000;
               next_s.long_done = 1'b0;
               if (snap == '0) begin
                  next_s.suppress = 1'b0;
               end else if ((snap & ~s.qual_map) != '0) begin
                  if (sleep_in) begin
                     next_s.suppress = 1'b1;
                     if (s.wake_en) begin
                        next_s.wake = 1'b1;
                        next_s.irq_flag = 1'b1;
                     end
                  end else if (!s.suppress) begin
                     // Normal codes, up to three keys.
                     next_s.code_first = normal_codes[7:0];
                     next_s.code_second = normal_codes[15:8];
                     next_s.code_third = normal_codes[23:16];
                     next_s.irq_flag = 1'b1;
                  end
               end
            end else if (s.qual_map != '0 && long_en && !s.long_done && !s.suppress && !sleep_in) begin
               next_s.long_cnt = s.long_cnt + 9'h001;
               if (s.long_cnt + 9'h001 >= long_target) begin
                  next_s.long_done = 1'b1;
                  next_s.code_first = long_codes[7:0];
                  next_s.code_second = long_codes[15:8];
                  next_s.code_third = long_codes[23:16];
                  next_s.irq_flag = 1'b1;
               end
            end
         end
      end

      // One-hot drive of the four rows.
      // The rows follow the enable as it is written, so the first row after enabling stands a full period.
      next_s.rows = next_s.ctl_one[kms_pkg::CTL1_SCAN_EN] ? (4'h1 << next_s.row_idx) : 4'h0;
      // Enable gates the flag; level holds until cleared.
      next_s.irq = next_s.irq_flag & next_s.irq_en;
   end

   // -------------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         s <= '0;
         s.ctl_one <= kms_pkg::CTL1_RESET;
         s.code_first <= kms_pkg::CODE_RESET;
         s.code_second <= kms_pkg::CODE_RESET;
         s.code_third <= kms_pkg::CODE_RESET;
      end else begin
         s <= next_s;
      end
   end

   assign reg_rdata_out = s.rdata;
   assign row_drive_outputs_out = s.rows;
   assign wake_out = s.wake;
   assign irq_out = s.irq;

endmodule : kms_keypad_scanner

/* test/kms_monitor.sv */
module kms_monitor #(
   parameter int unsigned SCAN_BASE_CYCLES = 2
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   // Watched ports
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic [kms_pkg::ROWS-1:0] row_drive_outputs_out,
   input wire logic [kms_pkg::COLS-1:0] column_sense_inputs_in,
   input wire logic sleep_in,
   input wire logic wake_out,
   input wire logic irq_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (sys_rst_in);
   sequence s_flag_read;
      reg_rd_in && reg_addr_in == kms_pkg::ADDR_IRQ_FLAG;
   endsequence
   sequence s_mask_off;
      reg_wr_in && reg_addr_in == kms_pkg::ADDR_IRQ_ENABLE && !reg_wdata_in[4];
   endsequence
   a_rows_onehot: assert property ($onehot0(row_drive_outputs_out))
      else $error("more than one row driven");
   a_row_stands: assert property ((row_drive_outputs_out != '0 && $changed(row_drive_outputs_out))
      |=> $stable(row_drive_outputs_out)) else $error("row period too short");
   a_scan_off: assert property (reg_wr_in && reg_addr_in == kms_pkg::ADDR_CTL_ONE && !reg_wdata_in[7]
      |-> ##3 row_drive_outputs_out == '0) else $error("rows driven with scan off");
   a_flag_layout: assert property (s_flag_read |=> (reg_rdata_out & 8'hEF) == 8'h00)
      else $error("flag read shows foreign bits");
   a_flag_clear: assert property (s_flag_read |-> ##2 !irq_out)
      else $error("interrupt stays after flag read");
   a_mask_gates: assert property (s_mask_off |-> ##2 !irq_out)
      else $error("interrupt while masked");
   a_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
      else $error("read data outside its cycle");
   a_ctl_reserved: assert property (reg_rd_in && reg_addr_in == kms_pkg::ADDR_CTL_ONE
      |=> !reg_rdata_out[3]) else $error("reserved control bit set");
   a_wake_pulse: assert property (wake_out |=> !wake_out)
      else $error("wake longer than one cycle");
   a_wake_asleep: assert property (wake_out |-> $past(sleep_in))
      else $error("wake while awake");
endmodule : kms_monitor

bind kms_keypad_scanner kms_monitor #(.SCAN_BASE_CYCLES(SCAN_BASE_CYCLES)) u_mon (
   .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
   .reg_rdata_out(reg_rdata_out), .row_drive_outputs_out(row_drive_outputs_out),
   .column_sense_inputs_in(column_sense_inputs_in), .sleep_in(sleep_in),
   .wake_out(wake_out), .irq_out(irq_out));

/* test/kms_key_matrix.sv */
module kms_key_matrix (
   // Row drive and switch states
   input wire logic [kms_pkg::ROWS-1:0] row_in,
   input wire logic [kms_pkg::KEYS-1:0] pressed_in,
   // Column sense
   output logic [kms_pkg::COLS-1:0] col_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // closed switch joins row to column
   // Columns rest low through their pull-down when no driven row reaches them.
   always_comb begin
      col_out = '0;
      for (int r = 0; r < kms_pkg::ROWS; r++) begin
         for (int c = 0; c < kms_pkg::COLS; c++) begin
            if (row_in[r] && pressed_in[r*kms_pkg::COLS+c]) begin
               col_out[c] = 1'b1;
            end
         end
      end
   end
endmodule : kms_key_matrix

/* test/tb.sv */
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [7:0] reg_addr_in = 8'h00;
   logic [7:0] reg_wdata_in = 8'h00;
   logic reg_wr_in = 1'b0;
   logic reg_rd_in = 1'b0;
   logic sleep_in = 1'b0;
   logic [kms_pkg::KEYS-1:0] keys = '0;
   logic [7:0] reg_rdata_out;
   logic [kms_pkg::ROWS-1:0] rows;
   logic [kms_pkg::COLS-1:0] cols;
   logic wake_out;
   logic irq_out;
   logic [7:0] exp_q[$];
   logic pend = 1'b0;
   logic [7:0] code;
   int err_count = 0;
   int checked = 0;
   int press[3] = '{19, 0, 12};
   int r;
   int c;
   // The short scan base keeps a frame at eight clocks.
   kms_keypad_scanner #(.SCAN_BASE_CYCLES(2)) DUT (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out), .row_drive_outputs_out(rows), .column_sense_inputs_in(cols),
      .sleep_in(sleep_in), .wake_out(wake_out), .irq_out(irq_out));
   kms_key_matrix u_keys (.row_in(rows), .pressed_in(keys), .col_out(cols));
   initial begin
      forever #5 ref_clk_in = ~ref_clk_in;
   end
   // ------------------------------------------------------------
   // Bus tasks and checking
   // ------------------------------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge ref_clk_in);
      reg_wr_in <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge ref_clk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      exp_q.push_back(e);
      @(posedge ref_clk_in);
      reg_rd_in <= 1'b0;
   endtask : rd
   // Waits on a settled level; the pulse of wake is seen at exactly one edge.
   task automatic wait_hi(input logic w);
      int n;
      n = 0;
      while ((w ? wake_out : irq_out) !== 1'b1 && n < 3000) begin
         @(posedge ref_clk_in);
         n++;
      end
      if (n >= 3000) begin
         err_count++;
         $display("[FAIL] %0t wait timed out", $time);
         finish_test();
      end
   endtask : wait_hi
   always @(negedge ref_clk_in) begin
      if (pend && exp_q.size() > 0) begin
         chk(reg_rdata_out, exp_q.pop_front());
      end
      pend = reg_rd_in;
   end
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      void'($urandom(8238));
      repeat (2) @(posedge ref_clk_in);
      sys_rst_in <= 1'b0;
      rd(kms_pkg::ADDR_CTL_ONE, 8'h00);
      rd(kms_pkg::ADDR_CODE_FIRST, 8'h00);
      rd(8'hC7, 8'h00);
      wr(kms_pkg::ADDR_CTL_ONE, 8'hFF);
      rd(kms_pkg::ADDR_CTL_ONE, 8'hF7);
      wr(kms_pkg::ADDR_CTL_TWO, 8'hFF);
      rd(kms_pkg::ADDR_CTL_TWO, 8'h8C);
      wr(kms_pkg::ADDR_CTL_TWO, 8'h00);
      $display("test registers done");
      wr(kms_pkg::ADDR_IRQ_ENABLE, 8'h10);
      wr(kms_pkg::ADDR_CTL_ONE, 8'h80);
      foreach (press[i]) begin
         keys[press[i]] <= 1'b1;
         wait_hi(1'b0);
         rd(kms_pkg::ADDR_IRQ_FLAG, 8'h10);
         repeat (4) @(posedge ref_clk_in);
         chk({7'h00, irq_out}, 8'h00);
      end
      rd(kms_pkg::ADDR_CODE_FIRST, 8'h00);
      rd(kms_pkg::ADDR_CODE_SECOND, 8'h22);
      rd(kms_pkg::ADDR_CODE_THIRD, 8'h34);
      rd(kms_pkg::ADDR_CTL_TWO, 8'h03);
      keys <= '0;
      repeat (100) @(posedge ref_clk_in);
      rd(kms_pkg::ADDR_CTL_TWO, 8'h00);
      rd(kms_pkg::ADDR_IRQ_FLAG, 8'h00);
      $display("test multi key done");
      wr(kms_pkg::ADDR_CTL_ONE, 8'hC0);
      repeat (2) begin
         r = $urandom % 4;
         c = $urandom % 5;
         code = {2'b00, r[1:0], 1'b0, c[2:0]};
         keys[r*5+c] <= 1'b1;
         wait_hi(1'b0);
         rd(kms_pkg::ADDR_IRQ_FLAG, 8'h10);
         rd(kms_pkg::ADDR_CODE_FIRST, code);
         rd(kms_pkg::ADDR_CODE_SECOND, 8'h00);
         repeat (4) @(posedge ref_clk_in);
         wait_hi(1'b0);
         rd(kms_pkg::ADDR_CODE_FIRST, code | 8'h80);
         rd(kms_pkg::ADDR_IRQ_FLAG, 8'h10);
         keys <= '0;
         repeat (60) @(posedge ref_clk_in);
      end
      $display("test long key done");
      wr(kms_pkg::ADDR_CTL_ONE, 8'h90);
      wr(kms_pkg::ADDR_IRQ_ENABLE, 8'h00);
      keys[7] <= 1'b1;
      repeat (100) @(posedge ref_clk_in);
      chk({7'h00, irq_out}, 8'h00);
      rd(kms_pkg::ADDR_IRQ_FLAG, 8'h10);
      rd(kms_pkg::ADDR_CODE_FIRST, 8'h12);
      keys <= '0;
      repeat (60) @(posedge ref_clk_in);
      $display("test polling done");
      wr(kms_pkg::ADDR_CTL_TWO, 8'h80);
      wr(kms_pkg::ADDR_IRQ_ENABLE, 8'h10);
      sleep_in <= 1'b1;
      keys[5] <= 1'b1;
      wait_hi(1'b1);
      sleep_in <= 1'b0;
      repeat (3) @(posedge ref_clk_in);
      chk({7'h00, irq_out}, 8'h01);
      rd(kms_pkg::ADDR_IRQ_FLAG, 8'h10);
      rd(kms_pkg::ADDR_CODE_FIRST, 8'h12);
      $display("test wake done");
      wr(kms_pkg::ADDR_CTL_ONE, 8'h00);
      repeat (4) @(posedge ref_clk_in);
      chk({4'h0, rows}, 8'h00);
      $display("test scan off done");
      finish_test();
   end
endmodule : tb
